// ===== cmpdc_regs.svh
/*
  Register offsets, field positions, reset values and select codes of the
  comparator digital control block.
  Assumes inclusion by bare name from the block's design files.
*/
`ifndef CMPDC_REGS_SVH
`define CMPDC_REGS_SVH

`define CMPDC_ADDR_CTRL0 8'h9b
`define CMPDC_ADDR_MODE 8'h9d
`define CMPDC_ADDR_MUX 8'h9f
`define CMPDC_ADDR_CTRL1 8'h99

`define CMPDC_CTRL0_RESET 8'h00
`define CMPDC_MODE_RESET 8'h02
`define CMPDC_MUX_RESET 8'h00
`define CMPDC_CTRL1_RESET 8'h00

`define CMPDC_CTRL0_ON 7
`define CMPDC_CTRL0_LEVEL 6
`define CMPDC_CTRL0_RISE 5
`define CMPDC_CTRL0_FALL 4
`define CMPDC_CTRL0_PHYS_HI 3
`define CMPDC_CTRL0_PHYS_LO 2
`define CMPDC_CTRL0_NHYS_HI 1
`define CMPDC_CTRL0_NHYS_LO 0

`define CMPDC_MODE_LATCH 7
`define CMPDC_MODE_INV 6
`define CMPDC_MODE_RIE 5
`define CMPDC_MODE_FIE 4
`define CMPDC_MODE_INPUT_CONNECTION_MODE_HI 3
`define CMPDC_MODE_INPUT_CONNECTION_MODE_LO 2
`define CMPDC_MODE_RESP_HI 1
`define CMPDC_MODE_RESP_LO 0

`define CMPDC_MUX_NEG_HI 3
`define CMPDC_MUX_NEG_LO 0
`define CMPDC_MUX_POS_HI 7
`define CMPDC_MUX_POS_LO 4

`define CMPDC_CTRL1_HOLD 7

`define CMPDC_NEG_LAST_PORT 4'h8
`define CMPDC_NEG_OPEN 4'h9
`define CMPDC_NEG_GND 4'ha
`define CMPDC_NEG_SUPPLY 4'hb

`endif

// ===== cmpdc_pkg.sv
/*
  Types shared by the comparator digital control block.
  Assumes nothing of its surroundings.
*/
`default_nettype none

package cmpdc_pkg;

  typedef enum logic [1:0] {
    CMPDC_DIRECT,
    CMPDC_NEG_GROUND,
    CMPDC_NEG_DAC,
    CMPDC_POS_DAC
  } cmpdc_input_connection_mode_t;

  typedef logic [7:0] cmpdc_byte_t;
  typedef logic [3:0] cmpdc_sel_t;

endpackage

`default_nettype wire

// ===== cmpdc_out_if.sv
/*
  Carrier between the register side and the output stage of the comparator.
  Assumes both ends run on the same core clock.
*/
`timescale 1ns/10ps
`default_nettype none

interface cmpdc_out_if;
  logic enable;
  logic invert;
  logic hold_en;
  logic hold_gate;
  logic level;
  logic rise;
  logic fall;

  modport stage (
    input enable,
    input invert,
    input hold_en,
    input hold_gate,
    output level,
    output rise,
    output fall
  );

  modport ctrl (
    output enable,
    output invert,
    output hold_en,
    output hold_gate,
    input level,
    input rise,
    input fall
  );
endinterface

`default_nettype wire

// ===== cmpdc_out_stage.sv
/*
  Output stage: synchroniser, inversion, inhibit hold, enable gating and
  edge detection of the comparator decision.
  Assumes raw_in is asynchronous to clk and hold_gate is synchronous.
*/
`timescale 1ns/10ps
`default_nettype none

module cmpdc_out_stage (
  input wire logic clk,
  input wire logic rst,
  input wire logic raw_in,
  cmpdc_out_if.stage port_if
);
  import cmpdc_pkg::*;

  logic sync_a;
  logic sync_b;
  logic held;
  logic level;
  logic prev;

  always_ff @(posedge clk) begin
    if (rst) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
    end else begin
      sync_a <= raw_in;
      sync_b <= sync_a;
    end
  end

  // Inversion sits ahead of the hold so a held value stays as seen
  always_ff @(posedge clk) begin
    if (rst) begin
      held <= 1'b0;
    end else if (!(port_if.hold_en && !port_if.hold_gate)) begin
      held <= sync_b ^ port_if.invert;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      level <= 1'b0;
      prev <= 1'b0;
    end else begin
      level <= port_if.enable & held;
      prev <= level;
    end
  end

  assign port_if.level = level;
  assign port_if.rise = level & ~prev;
  assign port_if.fall = ~level & prev;
endmodule // cmpdc_out_stage

`default_nettype wire

// ===== cmpdc_top.sv
/*
  Comparator digital control: special-function registers, input routing
  decode, output routing, edge flags and interrupt request.
  Assumes a single-cycle register bus on SYS_CLK, an analog core that takes
  the routing controls, and a raw comparator decision asynchronous to SYS_CLK.
*/
`timescale 1ns/10ps
`default_nettype none
`include "cmpdc_regs.svh"

module cmpdc_top (
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire cmpdc_pkg::cmpdc_byte_t SFR_ADDR,
  input wire cmpdc_pkg::cmpdc_byte_t SFR_WDATA,
  input wire logic SFR_WR,
  input wire logic SFR_RD,
  output cmpdc_pkg::cmpdc_byte_t SFR_RDATA,
  input wire logic CMP_RAW,
  input wire logic COUNTER_CHANNEL_TWO_OUT,
  input wire logic COUNTER_OVERFLOW,
  output logic CMP_POWER_ON,
  output logic [1:0] RESP_MODE,
  output logic [1:0] POS_HYSTERESIS,
  output logic [1:0] NEG_HYSTERESIS,
  output cmpdc_pkg::cmpdc_sel_t POS_CHANNEL,
  output logic [8:0] NEG_PORT_CHANNEL,
  output logic NEG_MUX_GROUND,
  output logic NEG_MUX_SUPPLY,
  output logic POS_DIRECT,
  output logic NEG_DIRECT,
  output logic NEG_GROUNDED,
  output logic DAC_ENABLE,
  output logic DAC_ON_POS,
  output logic DAC_ON_NEG,
  output logic OUT_SYNC,
  output logic OUT_ASYNC,
  output logic RESET_SOURCE,
  output logic KILL_TRIGGER,
  output logic IRQ
);
  import cmpdc_pkg::*;

  // Software-visible state
  logic comparator_on;
  logic rise_flag;
  logic fall_flag;
  logic [1:0] pos_hysteresis;
  logic [1:0] neg_hysteresis;
  logic latched_level;
  logic output_invert;
  logic rise_irq_enable;
  logic fall_irq_enable;
  cmpdc_input_connection_mode_t input_connection_mode;
  logic [1:0] resp_mode;
  cmpdc_sel_t neg_input_select;
  cmpdc_sel_t pos_input_select;
  logic output_hold_enable;

  // Bus decode
  logic wr_ctrl0;
  logic wr_mode;
  logic wr_mux;
  logic wr_ctrl1;
  cmpdc_byte_t read_mux;
  cmpdc_byte_t rdata;

  // Output stage
  logic output_level;
  logic rise_event;
  logic fall_event;

  // Routing decode
  logic [8:0] next_neg_port;
  logic next_neg_gnd;
  logic next_neg_supply;
  logic next_pos_direct;
  logic next_neg_direct;
  logic next_neg_grounded;
  logic next_dac_on_pos;
  logic next_dac_on_neg;
  logic [8:0] neg_port;
  logic neg_gnd;
  logic neg_supply;
  logic pos_direct;
  logic neg_direct;
  logic neg_grounded;
  logic dac_on_pos;
  logic dac_on_neg;
  logic irq;

  cmpdc_out_if out_bus ();

  assign wr_ctrl0 = SFR_WR && (SFR_ADDR == `CMPDC_ADDR_CTRL0);
  assign wr_mode = SFR_WR && (SFR_ADDR == `CMPDC_ADDR_MODE);
  assign wr_mux = SFR_WR && (SFR_ADDR == `CMPDC_ADDR_MUX);
  assign wr_ctrl1 = SFR_WR && (SFR_ADDR == `CMPDC_ADDR_CTRL1);

  // Control register zero, apart from the edge flags
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      comparator_on <= 1'(`CMPDC_CTRL0_RESET >> `CMPDC_CTRL0_ON);
      pos_hysteresis <= 2'h0;
      neg_hysteresis <= 2'h0;
    end else if (wr_ctrl0) begin
      comparator_on <= SFR_WDATA[`CMPDC_CTRL0_ON];
      pos_hysteresis <= SFR_WDATA[`CMPDC_CTRL0_PHYS_HI:`CMPDC_CTRL0_PHYS_LO];
      neg_hysteresis <= SFR_WDATA[`CMPDC_CTRL0_NHYS_HI:`CMPDC_CTRL0_NHYS_LO];
    end
  end

  // Edge flags: a hardware edge beats a software clear in the same cycle
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      rise_flag <= 1'b0;
      fall_flag <= 1'b0;
    end else begin
      if (rise_event) begin
        rise_flag <= 1'b1;
      end else if (wr_ctrl0) begin
        rise_flag <= SFR_WDATA[`CMPDC_CTRL0_RISE];
      end
      if (fall_event) begin
        fall_flag <= 1'b1;
      end else if (wr_ctrl0) begin
        fall_flag <= SFR_WDATA[`CMPDC_CTRL0_FALL];
      end
    end
  end

  // Mode register
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      output_invert <= 1'b0;
      rise_irq_enable <= 1'b0;
      fall_irq_enable <= 1'b0;
      input_connection_mode <= CMPDC_DIRECT;
      resp_mode <= 2'(`CMPDC_MODE_RESET);
    end else if (wr_mode) begin
      output_invert <= SFR_WDATA[`CMPDC_MODE_INV];
      rise_irq_enable <= SFR_WDATA[`CMPDC_MODE_RIE];
      fall_irq_enable <= SFR_WDATA[`CMPDC_MODE_FIE];
      input_connection_mode <= cmpdc_input_connection_mode_t'(SFR_WDATA[`CMPDC_MODE_INPUT_CONNECTION_MODE_HI:`CMPDC_MODE_INPUT_CONNECTION_MODE_LO]);
      resp_mode <= SFR_WDATA[`CMPDC_MODE_RESP_HI:`CMPDC_MODE_RESP_LO];
    end
  end

  // Level seen at the last counter overflow; software may also write it
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      latched_level <= 1'b0;
    end else if (COUNTER_OVERFLOW) begin
      latched_level <= output_level;
    end else if (wr_mode) begin
      latched_level <= SFR_WDATA[`CMPDC_MODE_LATCH];
    end
  end

  // Multiplexer register and control register one
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      neg_input_select <= 4'(`CMPDC_MUX_RESET);
      pos_input_select <= 4'(`CMPDC_MUX_RESET >> `CMPDC_MUX_POS_LO);
    end else if (wr_mux) begin
      neg_input_select <= SFR_WDATA[`CMPDC_MUX_NEG_HI:`CMPDC_MUX_NEG_LO];
      pos_input_select <= SFR_WDATA[`CMPDC_MUX_POS_HI:`CMPDC_MUX_POS_LO];
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      output_hold_enable <= 1'(`CMPDC_CTRL1_RESET >> `CMPDC_CTRL1_HOLD);
    end else if (wr_ctrl1) begin
      output_hold_enable <= SFR_WDATA[`CMPDC_CTRL1_HOLD];
    end
  end

  // Read path: reads change nothing; unmapped addresses read zero
  always_comb begin
    read_mux = 8'h00;
    unique case (SFR_ADDR)
      `CMPDC_ADDR_CTRL0: begin
        read_mux[`CMPDC_CTRL0_ON] = comparator_on;
        read_mux[`CMPDC_CTRL0_LEVEL] = output_level;
        read_mux[`CMPDC_CTRL0_RISE] = rise_flag;
        read_mux[`CMPDC_CTRL0_FALL] = fall_flag;
        read_mux[`CMPDC_CTRL0_PHYS_HI:`CMPDC_CTRL0_PHYS_LO] = pos_hysteresis;
        read_mux[`CMPDC_CTRL0_NHYS_HI:`CMPDC_CTRL0_NHYS_LO] = neg_hysteresis;
      end
      `CMPDC_ADDR_MODE: begin
        read_mux[`CMPDC_MODE_LATCH] = latched_level;
        read_mux[`CMPDC_MODE_INV] = output_invert;
        read_mux[`CMPDC_MODE_RIE] = rise_irq_enable;
        read_mux[`CMPDC_MODE_FIE] = fall_irq_enable;
        read_mux[`CMPDC_MODE_INPUT_CONNECTION_MODE_HI:`CMPDC_MODE_INPUT_CONNECTION_MODE_LO] = input_connection_mode;
        read_mux[`CMPDC_MODE_RESP_HI:`CMPDC_MODE_RESP_LO] = resp_mode;
      end
      `CMPDC_ADDR_MUX: begin
        read_mux[`CMPDC_MUX_NEG_HI:`CMPDC_MUX_NEG_LO] = neg_input_select;
        read_mux[`CMPDC_MUX_POS_HI:`CMPDC_MUX_POS_LO] = pos_input_select;
      end
      `CMPDC_ADDR_CTRL1: begin
        read_mux[`CMPDC_CTRL1_HOLD] = output_hold_enable;
      end
      default: begin
        read_mux = 8'h00;
      end
    endcase
  end

  // Read data holds its last value between reads
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      rdata <= 8'h00;
    end else if (SFR_RD) begin
      rdata <= read_mux;
    end
  end

  // Negative multiplexer: one switch per port channel
  genvar ch;
  generate
    for (ch = 0; ch <= `CMPDC_NEG_LAST_PORT; ch = ch + 1) begin : g_neg_port
      assign next_neg_port[ch] = (neg_input_select == 4'(ch));
    end
  endgenerate

  // Codes above the supply code, and the open code, close no switch
  assign next_neg_gnd = (neg_input_select == `CMPDC_NEG_GND);
  assign next_neg_supply = (neg_input_select == `CMPDC_NEG_SUPPLY);

  // Input connection arrangement
  always_comb begin
    next_pos_direct = 1'b1;
    next_neg_direct = 1'b1;
    next_neg_grounded = 1'b0;
    next_dac_on_pos = 1'b0;
    next_dac_on_neg = 1'b0;
    unique case (input_connection_mode)
      CMPDC_DIRECT: begin
        next_pos_direct = 1'b1;
        next_neg_direct = 1'b1;
      end
      CMPDC_NEG_GROUND: begin
        next_neg_direct = 1'b0;
        next_neg_grounded = 1'b1;
      end
      CMPDC_NEG_DAC: begin
        next_neg_direct = 1'b0;
        next_dac_on_neg = 1'b1;
      end
      CMPDC_POS_DAC: begin
        next_pos_direct = 1'b0;
        next_dac_on_pos = 1'b1;
      end
    endcase
  end

  // Routing is registered so the analog switches never see decode glitches
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      neg_port <= 9'h001;
      neg_gnd <= 1'b0;
      neg_supply <= 1'b0;
      pos_direct <= 1'b1;
      neg_direct <= 1'b1;
      neg_grounded <= 1'b0;
      dac_on_pos <= 1'b0;
      dac_on_neg <= 1'b0;
    end else begin
      neg_port <= next_neg_port;
      neg_gnd <= next_neg_gnd;
      neg_supply <= next_neg_supply;
      pos_direct <= next_pos_direct;
      neg_direct <= next_neg_direct;
      neg_grounded <= next_neg_grounded;
      dac_on_pos <= next_dac_on_pos;
      dac_on_neg <= next_dac_on_neg;
    end
  end

  // Interrupt request, one cycle behind the flags
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      irq <= 1'b0;
    end else begin
      irq <= (rise_flag & rise_irq_enable) | (fall_flag & fall_irq_enable);
    end
  end

  assign out_bus.enable = comparator_on;
  assign out_bus.invert = output_invert;
  assign out_bus.hold_en = output_hold_enable;
  assign out_bus.hold_gate = COUNTER_CHANNEL_TWO_OUT;
  assign output_level = out_bus.level;
  assign rise_event = out_bus.rise;
  assign fall_event = out_bus.fall;

  cmpdc_out_stage u_stage (
    .clk(SYS_CLK),
    .rst(RST),
    .raw_in(CMP_RAW),
    .port_if(out_bus)
  );

  assign SFR_RDATA = rdata;
  assign CMP_POWER_ON = comparator_on;
  assign RESP_MODE = resp_mode;
  assign POS_HYSTERESIS = pos_hysteresis;
  assign NEG_HYSTERESIS = neg_hysteresis;
  assign POS_CHANNEL = pos_input_select;
  assign NEG_PORT_CHANNEL = neg_port;
  assign NEG_MUX_GROUND = neg_gnd;
  assign NEG_MUX_SUPPLY = neg_supply;
  assign POS_DIRECT = pos_direct;
  assign NEG_DIRECT = neg_direct;
  assign NEG_GROUNDED = neg_grounded;
  assign DAC_ENABLE = dac_on_pos | dac_on_neg;
  assign DAC_ON_POS = dac_on_pos;
  assign DAC_ON_NEG = dac_on_neg;
  assign OUT_SYNC = output_level;
  // Raw path skips the hold: no clock to freeze it against
  assign OUT_ASYNC = comparator_on & (CMP_RAW ^ output_invert);
  assign RESET_SOURCE = output_level;
  assign KILL_TRIGGER = output_level;
  assign IRQ = irq;
endmodule // cmpdc_top

`default_nettype wire

// ===== cmpdc_top_chk.sv
/* Port-level assertions for cmpdc_top.
   Assumes it is bound into cmpdc_top; one clock domain. */
`timescale 1ns/10ps
`default_nettype none
module cmpdc_top_chk (
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire cmpdc_pkg::cmpdc_byte_t SFR_ADDR,
  input wire cmpdc_pkg::cmpdc_byte_t SFR_WDATA,
  input wire logic SFR_WR,
  input wire logic CMP_RAW,
  input wire logic COUNTER_CHANNEL_TWO_OUT,
  input wire logic CMP_POWER_ON,
  input wire logic [1:0] POS_HYSTERESIS,
  input wire logic [1:0] NEG_HYSTERESIS,
  input wire logic [8:0] NEG_PORT_CHANNEL,
  input wire logic NEG_MUX_GROUND,
  input wire logic NEG_MUX_SUPPLY,
  input wire logic POS_DIRECT,
  input wire logic NEG_DIRECT,
  input wire logic NEG_GROUNDED,
  input wire logic DAC_ENABLE,
  input wire logic DAC_ON_POS,
  input wire logic DAC_ON_NEG,
  input wire logic OUT_SYNC,
  input wire logic OUT_ASYNC,
  input wire logic RESET_SOURCE,
  input wire logic KILL_TRIGGER
);
  import cmpdc_pkg::*;
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RST);
  a_enable_write: assert property (SFR_WR && SFR_ADDR == 8'h9b |=> CMP_POWER_ON == $past(SFR_WDATA[7]))
    else $error("enable bit not applied");
  a_hyst_write: assert property (SFR_WR && SFR_ADDR == 8'h9b |=>
    {POS_HYSTERESIS, NEG_HYSTERESIS} == $past(SFR_WDATA[3:0])) else $error("hysteresis not applied");
  a_off_async: assert property (!CMP_POWER_ON |-> !OUT_ASYNC)
    else $error("async output high while off");
  a_off_sync: assert property (!CMP_POWER_ON ##1 !CMP_POWER_ON |-> !OUT_SYNC)
    else $error("sync output high while off");
  a_copies_match: assert property (RESET_SOURCE == OUT_SYNC && KILL_TRIGGER == OUT_SYNC)
    else $error("reset source or kill trigger differs");
  a_neg_single: assert property ($onehot0({NEG_PORT_CHANNEL, NEG_MUX_GROUND, NEG_MUX_SUPPLY}))
    else $error("several negative switches closed");
  a_dac_use: assert property (DAC_ENABLE == (DAC_ON_POS || DAC_ON_NEG) && !(DAC_ON_POS && DAC_ON_NEG))
    else $error("reference converter side inconsistent");
  a_dac_sides: assert property ((DAC_ON_POS |-> NEG_DIRECT && !POS_DIRECT) and
    (DAC_ON_NEG |-> POS_DIRECT && !NEG_DIRECT && !NEG_GROUNDED)) else $error("converter routing wrong");
  a_ground_neg: assert property (NEG_GROUNDED |-> POS_DIRECT && !NEG_DIRECT && !DAC_ENABLE)
    else $error("grounded routing wrong");
  a_sync_quiet: assert property ((!SFR_WR && $stable(CMP_RAW) && $stable(COUNTER_CHANNEL_TWO_OUT)
    && CMP_POWER_ON) [*6] |-> $stable(OUT_SYNC)) else $error("output moved with quiet inputs");
endmodule // cmpdc_top_chk
`default_nettype wire

// ===== cmpdc_analog_model.sv
/* Behavioural analog comparator core.
   Assumes the bench sets both input voltages as 8-bit codes. */
`timescale 1ns/10ps
`default_nettype none
module cmpdc_analog_model (
  input wire logic clk,
  input wire logic power,
  input wire logic neg_grounded,
  input wire logic slow,
  input wire logic [7:0] v_pos,
  input wire logic [7:0] v_neg,
  output logic raw
);
  logic [7:0] v_n;
  initial raw = 1'b0;
  assign v_n = neg_grounded ? 8'h00 : v_neg;
  // Unpowered core has no decision; toggling keeps a stale level from passing
  always @(posedge clk) begin
    if (slow) @(posedge clk);
    #3;
    if (power) raw = v_pos > v_n;
    else raw = ~raw;
  end
endmodule // cmpdc_analog_model
`default_nettype wire

// ===== comparator_digital_control_test.sv
/* Self-checking bench for cmpdc_top with the analog core model.
   Assumes design files, checker and model are compiled first. */
`timescale 1ns/10ps
`default_nettype none
module comparator_digital_control_test;
  import cmpdc_pkg::*;
  logic sys_clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, ch2 = 1'b1, ovf = 1'b0, slow = 1'b0;
  cmpdc_byte_t addr = 8'h00, wdata = 8'h00, rdata;
  logic [7:0] vp = 8'h10, vn = 8'h80;
  wire raw;
  logic pwr, sync_o, async_o, irq, pos_d, neg_d, neg_g, dac_p, dac_n, mgnd, msup;
  logic [1:0] phys, nhys, resp;
  logic [3:0] pchan;
  logic [8:0] nport;
  int miscompares = 0, n_checks = 0;
  logic [31:0] seed = 32'hfb4abfbb;
  cmpdc_top DUT (.SYS_CLK(sys_clk), .RST(rst), .SFR_ADDR(addr), .SFR_WDATA(wdata), .SFR_WR(wr),
    .SFR_RD(rd), .SFR_RDATA(rdata), .CMP_RAW(raw), .COUNTER_CHANNEL_TWO_OUT(ch2), .COUNTER_OVERFLOW(ovf),
    .CMP_POWER_ON(pwr), .RESP_MODE(resp), .POS_HYSTERESIS(phys), .NEG_HYSTERESIS(nhys), .POS_CHANNEL(pchan),
    .NEG_PORT_CHANNEL(nport), .NEG_MUX_GROUND(mgnd), .NEG_MUX_SUPPLY(msup), .POS_DIRECT(pos_d),
    .NEG_DIRECT(neg_d), .NEG_GROUNDED(neg_g), .DAC_ENABLE(), .DAC_ON_POS(dac_p), .DAC_ON_NEG(dac_n),
    .OUT_SYNC(sync_o), .OUT_ASYNC(async_o), .RESET_SOURCE(), .KILL_TRIGGER(), .IRQ(irq));
  cmpdc_analog_model core (.clk(sys_clk), .power(pwr), .neg_grounded(neg_g), .slow(slow), .v_pos(vp),
    .v_neg(vn), .raw(raw));
  always #5 sys_clk = ~sys_clk;
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    xs = t ^ (t << 5);
  endfunction
  function automatic logic [10:0] neg_exp(input logic [3:0] c);
    neg_exp = {(c <= 4'h8) ? 9'h001 << c : 9'h000, c == 4'ha, c == 4'hb};
  endfunction
  // Order: pos direct, neg direct, neg grounded, converter on pos, converter on neg
  function automatic logic [4:0] mode_exp(input logic [1:0] m);
    case (m)
      2'h0: mode_exp = 5'h18;
      2'h1: mode_exp = 5'h14;
      2'h2: mode_exp = 5'h11;
      default: mode_exp = 5'h0a;
    endcase
  endfunction
  task automatic chk(input logic [10:0] seen, input logic [10:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic wr_reg(input cmpdc_byte_t a, input cmpdc_byte_t d);
    @(posedge sys_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge sys_clk);
    wr <= 1'b0;
  endtask
  task automatic rd_chk(input cmpdc_byte_t a, input cmpdc_byte_t e);
    @(posedge sys_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge sys_clk);
    rd <= 1'b0;
    settle(1);
    chk(rdata, e);
  endtask
  // Eight cycles cover the slow core cycle plus the five-edge path to the flags
  task automatic set_v(input logic [7:0] p, input logic [7:0] n, input logic c);
    @(posedge sys_clk);
    vp <= p;
    vn <= n;
    ch2 <= c;
    settle(8);
  endtask
  task automatic close_out;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge sys_clk);
    miscompares++;
    close_out;
  end
  initial begin
    int i;
    logic e;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    settle(1);
    chk({nport, pos_d, neg_d}, {9'h001, 2'h3});
    rd_chk(8'h9b, 8'h00);
    rd_chk(8'h9d, 8'h02);
    rd_chk(8'h99, 8'h00);
    rd_chk(8'h55, 8'h00);
    for (i = 0; i < 16; i++) begin
      wr_reg(8'h9f, {i[1:0], i[3:2], i[3:0]});
      settle(2);
      chk({nport, mgnd, msup}, neg_exp(i[3:0]));
      chk(pchan, {i[1:0], i[3:2]});
      rd_chk(8'h9f, {i[1:0], i[3:2], i[3:0]});
    end
    for (i = 0; i < 4; i++) begin
      wr_reg(8'h9d, {4'h0, i[1:0], i[1:0]});
      settle(2);
      chk({pos_d, neg_d, neg_g, dac_p, dac_n, resp}, {mode_exp(i[1:0]), i[1:0]});
    end
    wr_reg(8'h9d, 8'h02);
    seed = xs(seed);
    wr_reg(8'h9b, {4'hc, seed[3:0]});
    settle(8);
    chk({pwr, phys, nhys}, {1'b1, seed[3:0]});
    wr_reg(8'h9b, 8'h80);
    rd_chk(8'h9b, 8'h80);
    wr_reg(8'h9d, 8'h32);
    set_v(8'hc0, 8'h40, 1'b1);
    rd_chk(8'h9b, 8'he0);
    chk(irq, 1'b1);
    rd_chk(8'h9b, 8'he0);
    set_v(8'h20, 8'h40, 1'b1);
    rd_chk(8'h9b, 8'hb0);
    wr_reg(8'h9b, 8'h90);
    settle(2);
    chk(irq, 1'b1);
    wr_reg(8'h9d, 8'h22);
    settle(2);
    chk(irq, 1'b0);
    wr_reg(8'h9b, 8'h80);
    settle(2);
    chk(irq, 1'b0);
    wr_reg(8'h9d, 8'h02);
    set_v(8'hc0, 8'h40, 1'b1);
    chk({irq, sync_o, async_o}, 3'h3);
    wr_reg(8'h9d, 8'h42);
    settle(8);
    chk({sync_o, async_o}, 2'h0);
    rd_chk(8'h9b, 8'hb0);
    wr_reg(8'h9d, 8'h02);
    set_v(8'hc0, 8'h40, 1'b1);
    wr_reg(8'h99, 8'h80);
    rd_chk(8'h99, 8'h80);
    set_v(8'hc0, 8'h40, 1'b0);
    set_v(8'h20, 8'h40, 1'b0);
    chk({sync_o, async_o}, 2'h2);
    set_v(8'h20, 8'h40, 1'b1);
    chk(sync_o, 1'b0);
    wr_reg(8'h99, 8'h00);
    set_v(8'hc0, 8'h40, 1'b1);
    wr_reg(8'h9b, 8'h00);
    settle(3);
    chk({pwr, sync_o, async_o}, 3'h0);
    wr_reg(8'h9b, 8'h80);
    for (i = 0; i < 24; i++) begin
      seed = xs(seed);
      wr_reg(8'h9d, {1'b0, seed[17], 6'h02});
      slow <= seed[16];
      set_v(seed[7:0], seed[15:8], 1'b1);
      e = (seed[7:0] > seed[15:8]) ^ seed[17];
      chk({sync_o, async_o}, {2{e}});
      @(posedge sys_clk);
      ovf <= 1'b1;
      @(posedge sys_clk);
      ovf <= 1'b0;
      rd_chk(8'h9d, {e, seed[17], 6'h02});
    end
    close_out;
  end
endmodule // comparator_digital_control_test
bind cmpdc_top cmpdc_top_chk chk_i (.SYS_CLK, .RST, .SFR_ADDR, .SFR_WDATA, .SFR_WR, .CMP_RAW,
  .COUNTER_CHANNEL_TWO_OUT, .CMP_POWER_ON, .POS_HYSTERESIS, .NEG_HYSTERESIS, .NEG_PORT_CHANNEL,
  .NEG_MUX_GROUND, .NEG_MUX_SUPPLY, .POS_DIRECT, .NEG_DIRECT, .NEG_GROUNDED, .DAC_ENABLE, .DAC_ON_POS,
  .DAC_ON_NEG, .OUT_SYNC, .OUT_ASYNC, .RESET_SOURCE, .KILL_TRIGGER);
`default_nettype wire
